// >>> rxs_pkg.sv
package rxs_pkg;

  // Counter read offsets (byte addresses of the statistics block)
  localparam logic [7:0] OFF_UNI_BYTES = 8'h1c;
  localparam logic [7:0] OFF_BC_BYTES = 8'h20;
  localparam logic [7:0] OFF_MC_BYTES = 8'h24;
  localparam logic [7:0] OFF_UNI_FRAMES = 8'h28;
  localparam logic [7:0] OFF_BC_FRAMES = 8'h2c;
  localparam logic [7:0] OFF_MC_FRAMES = 8'h30;
  localparam logic [7:0] OFF_PAUSE = 8'h34;
  localparam logic [7:0] OFF_BIN_BASE = 8'h38;
  localparam logic [7:0] OFF_LPI_TRANS = 8'h54;
  localparam logic [7:0] OFF_LPI_TIME = 8'h58;
  localparam logic [7:0] OFF_TX_FCS = 8'h5c;
  localparam logic [7:0] OFF_CONTROL = 8'hc0;
  localparam logic [7:0] OFF_STATUS = 8'hc4;

  // Control register field positions
  localparam int CTL_PAUSE_FWD = 0;
  localparam int CTL_BCAST = 1;
  localparam int CTL_LPI_EN = 2;
  localparam int CTL_VLAN_STRIP = 3;
  localparam int CTL_FCS_STRIP = 4;
  localparam logic [4:0] CTL_RESET = 5'h02;

  // Length bin edges
  localparam logic [15:0] LEN_64 = 16'h0040;
  localparam logic [15:0] LEN_127 = 16'h007f;
  localparam logic [15:0] LEN_255 = 16'h00ff;
  localparam logic [15:0] LEN_511 = 16'h01ff;
  localparam logic [15:0] LEN_1023 = 16'h03ff;
  localparam logic [15:0] LEN_1518 = 16'h05ee;
  localparam logic [15:0] VLAN_BYTES = 16'h0004;
  localparam logic [15:0] FCS_BYTES = 16'h0004;
  localparam int NUM_BINS = 7;

  // Timing
  localparam int CLOCK_HZ = 20000000;
  localparam int TICK_US = 1;
  localparam int US_CYCLES = (CLOCK_HZ / 1000000) * TICK_US;

  // End-of-frame report from the receive path and filter engine
  typedef struct packed {
    logic [15:0] length;
    logic hasVlan;
    logic isUnicast;
    logic isBroadcast;
    logic isMulticast;
    logic isPause;
    logic hasError;
    logic filterFail;
    logic overflow;
  } rxs_frame_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] writeData;
    logic writeStrobe;
    logic readStrobe;
  } rxs_bus_type;

endpackage

// >>> rxs_counters.sv
`timescale 1ns/100ps

// Summary of operation
// - 32-bit byte total of error-free unicast frames.
// - Unicast/multicast counters skip filter fails, dropped pause frames, overflow losses.
// - Byte tallies drop VLAN tag and FCS when their stripping is on.
// - 32-bit byte total of error-free broadcast frames.
// - Broadcast counters stop when broadcast accept is off; skip overflow losses.
// - 32-bit byte total of error-free multicast frames.
// - 20-bit count of error-free unicast frames.
// - 20-bit count of error-free broadcast frames.
// - 20-bit count of error-free multicast frames.
// - 20-bit pause frame count, including pause frames failing filtering.
// - 20-bit count of 64-byte frames with the unicast exclusions.
// - 20-bit counters for the five bins from 65 to 1518 bytes.
// - 20-bit count of error-free frames above 1518 bytes.
// - Bins from 65 bytes skip filter fails and overflow losses.
// - 32-bit count of rising edges of the receive idle indication.
// - Both idle counters held cleared while idle feature enable is low.
// - 32-bit idle time in microsecond units.
// - Idle counters keep running in both suspend states and normal power.
// - 20-bit count of transmitted frames with bad checksum, forced ones included.
module rxs_counters #(
  parameter int BYTE_WIDTH = 32,
  parameter int FRAME_WIDTH = 20,
  parameter int LPI_WIDTH = 32
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic frameDone,
  input wire rxs_pkg::rxs_frame_type frameInfo,
  input wire logic lpiIndication,
  input wire logic suspendStateZero,
  input wire logic suspendStateThree,
  input wire logic txBadFcsFrame,
  input wire rxs_pkg::rxs_bus_type bus,
  output logic [31:0] readData
);

  ////////////////////////////////////////////////////////////////////////////
  // Control register and register declarations

  logic [4:0] control;
  logic [BYTE_WIDTH-1:0] uniBytes;
  logic [BYTE_WIDTH-1:0] bcBytes;
  logic [BYTE_WIDTH-1:0] mcBytes;
  logic [FRAME_WIDTH-1:0] uniFrames;
  logic [FRAME_WIDTH-1:0] bcFrames;
  logic [FRAME_WIDTH-1:0] mcFrames;
  logic [FRAME_WIDTH-1:0] pauseFrames;
  logic [FRAME_WIDTH-1:0] txFcsErrors;
  logic [FRAME_WIDTH-1:0] binCount [rxs_pkg::NUM_BINS];
  logic [LPI_WIDTH-1:0] lpiTransitions;
  logic [LPI_WIDTH-1:0] lpiTime;
  logic lpiLast;
  logic [7:0] usCount;
  logic usTick;

  wire logic pauseForward = control[rxs_pkg::CTL_PAUSE_FWD];
  wire logic broadcastAccept = control[rxs_pkg::CTL_BCAST];
  wire logic lpiFeatureEnable = control[rxs_pkg::CTL_LPI_EN];

  // Writable control bits steer the counting
  always_ff @(posedge clock) begin
    if (reset) begin
      control <= rxs_pkg::CTL_RESET;
    end else if (bus.writeStrobe && bus.addr == rxs_pkg::OFF_CONTROL) begin
      control <= bus.writeData[4:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame qualification, all sampled on the end-of-frame strobe

  logic goodFrame;
  logic pauseDropped;
  logic uniMcOk;
  logic binOk;
  logic [15:0] frameBytes;
  logic [15:0] vlanCut;
  logic [15:0] fcsCut;
  logic [rxs_pkg::NUM_BINS-1:0] binHit;

  assign goodFrame = frameDone && !frameInfo.hasError;
  // Pause frames are consumed by the MAC unless forwarding is on
  assign pauseDropped = frameInfo.isPause && !pauseForward;
  assign uniMcOk = goodFrame && !frameInfo.filterFail && !pauseDropped && !frameInfo.overflow;
  assign binOk = goodFrame && !frameInfo.filterFail && !frameInfo.overflow;

  assign vlanCut = (control[rxs_pkg::CTL_VLAN_STRIP] && frameInfo.hasVlan)
                   ? rxs_pkg::VLAN_BYTES : 16'h0000;
  assign fcsCut = control[rxs_pkg::CTL_FCS_STRIP] ? rxs_pkg::FCS_BYTES : 16'h0000;
  // Clamp so a runt report never underflows the tally
  assign frameBytes = (frameInfo.length > vlanCut + fcsCut)
                      ? frameInfo.length - vlanCut - fcsCut : 16'h0000;

  assign binHit[0] = uniMcOk && frameInfo.length == rxs_pkg::LEN_64;
  assign binHit[1] = binOk && frameInfo.length > rxs_pkg::LEN_64
                     && frameInfo.length <= rxs_pkg::LEN_127;
  assign binHit[2] = binOk && frameInfo.length > rxs_pkg::LEN_127
                     && frameInfo.length <= rxs_pkg::LEN_255;
  assign binHit[3] = binOk && frameInfo.length > rxs_pkg::LEN_255
                     && frameInfo.length <= rxs_pkg::LEN_511;
  assign binHit[4] = binOk && frameInfo.length > rxs_pkg::LEN_511
                     && frameInfo.length <= rxs_pkg::LEN_1023;
  assign binHit[5] = binOk && frameInfo.length > rxs_pkg::LEN_1023
                     && frameInfo.length <= rxs_pkg::LEN_1518;
  assign binHit[6] = binOk && frameInfo.length > rxs_pkg::LEN_1518;

  ////////////////////////////////////////////////////////////////////////////
  // Byte counters; natural overflow wraps to zero

  always_ff @(posedge clock) begin
    if (reset) begin
      uniBytes <= '0;
    end else if (uniMcOk && frameInfo.isUnicast) begin
      uniBytes <= uniBytes + BYTE_WIDTH'(frameBytes);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      bcBytes <= '0;
    end else if (goodFrame && frameInfo.isBroadcast && broadcastAccept && !frameInfo.overflow) begin
      bcBytes <= bcBytes + BYTE_WIDTH'(frameBytes);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      mcBytes <= '0;
    end else if (uniMcOk && frameInfo.isMulticast) begin
      mcBytes <= mcBytes + BYTE_WIDTH'(frameBytes);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame counters

  always_ff @(posedge clock) begin
    if (reset) begin
      uniFrames <= '0;
    end else if (uniMcOk && frameInfo.isUnicast) begin
      uniFrames <= uniFrames + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      bcFrames <= '0;
    end else if (goodFrame && frameInfo.isBroadcast && broadcastAccept && !frameInfo.overflow) begin
      bcFrames <= bcFrames + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      mcFrames <= '0;
    end else if (uniMcOk && frameInfo.isMulticast) begin
      mcFrames <= mcFrames + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pauseFrames <= '0;
    end else if (goodFrame && frameInfo.isPause) begin
      pauseFrames <= pauseFrames + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      txFcsErrors <= '0;
    end else if (txBadFcsFrame) begin
      txFcsErrors <= txFcsErrors + 1'b1;
    end
  end

  for (genvar b = 0; b < rxs_pkg::NUM_BINS; b++) begin : gBin
    always_ff @(posedge clock) begin
      if (reset) begin
        binCount[b] <= '0;
      end else if (binHit[b]) begin
        binCount[b] <= binCount[b] + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-power idle statistics; suspend inputs never gate them

  // Microsecond tick from the core clock
  always_ff @(posedge clock) begin
    if (reset || !lpiFeatureEnable) begin
      usCount <= '0;
      usTick <= 1'b0;
    end else if (usCount == 8'(rxs_pkg::US_CYCLES - 1)) begin
      usCount <= '0;
      usTick <= 1'b1;
    end else begin
      usCount <= usCount + 1'b1;
      usTick <= 1'b0;
    end
  end

  // Edge history of the idle indication
  always_ff @(posedge clock) begin
    if (reset) begin
      lpiLast <= 1'b0;
    end else begin
      lpiLast <= lpiIndication;
    end
  end

  always_ff @(posedge clock) begin
    if (reset || !lpiFeatureEnable) begin
      lpiTransitions <= '0;
    end else if (lpiIndication && !lpiLast) begin
      lpiTransitions <= lpiTransitions + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset || !lpiFeatureEnable) begin
      lpiTime <= '0;
    end else if (usTick && lpiIndication) begin
      lpiTime <= lpiTime + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data valid the cycle after the read strobe

  logic [31:0] next_readData;

  // Counters narrower than 32 bits read zero above
  always_comb begin
    next_readData = 32'h0000_0000;
    unique case (bus.addr)
      rxs_pkg::OFF_UNI_BYTES: next_readData = 32'(uniBytes);
      rxs_pkg::OFF_BC_BYTES: next_readData = 32'(bcBytes);
      rxs_pkg::OFF_MC_BYTES: next_readData = 32'(mcBytes);
      rxs_pkg::OFF_UNI_FRAMES: next_readData = 32'(uniFrames);
      rxs_pkg::OFF_BC_FRAMES: next_readData = 32'(bcFrames);
      rxs_pkg::OFF_MC_FRAMES: next_readData = 32'(mcFrames);
      rxs_pkg::OFF_PAUSE: next_readData = 32'(pauseFrames);
      rxs_pkg::OFF_BIN_BASE: next_readData = 32'(binCount[0]);
      rxs_pkg::OFF_BIN_BASE + 8'h04: next_readData = 32'(binCount[1]);
      rxs_pkg::OFF_BIN_BASE + 8'h08: next_readData = 32'(binCount[2]);
      rxs_pkg::OFF_BIN_BASE + 8'h0c: next_readData = 32'(binCount[3]);
      rxs_pkg::OFF_BIN_BASE + 8'h10: next_readData = 32'(binCount[4]);
      rxs_pkg::OFF_BIN_BASE + 8'h14: next_readData = 32'(binCount[5]);
      rxs_pkg::OFF_BIN_BASE + 8'h18: next_readData = 32'(binCount[6]);
      rxs_pkg::OFF_LPI_TRANS: next_readData = 32'(lpiTransitions);
      rxs_pkg::OFF_LPI_TIME: next_readData = 32'(lpiTime);
      rxs_pkg::OFF_TX_FCS: next_readData = 32'(txFcsErrors);
      rxs_pkg::OFF_CONTROL: next_readData = {27'h0, control};
      rxs_pkg::OFF_STATUS: next_readData = {30'h0, suspendStateThree || suspendStateZero, lpiLast};
      default: next_readData = 32'h0000_0000;
    endcase
  end

  // Unmapped or idle cycles return zero
  always_ff @(posedge clock) begin
    if (reset) begin
      readData <= '0;
    end else if (bus.readStrobe) begin
      readData <= next_readData;
    end else begin
      readData <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  uniFrameCount_a: assert property (@(posedge clock) disable iff (reset)
    (frameDone && !frameInfo.hasError && frameInfo.isUnicast && !frameInfo.filterFail
     && !frameInfo.overflow && !frameInfo.isPause)
    |=> uniFrames == $past(uniFrames) + 1'b1)
    else $error("unicast frame not counted");

  filterSkip_a: assert property (@(posedge clock) disable iff (reset)
    (frameDone && frameInfo.filterFail && !frameInfo.isBroadcast) |=>
    $stable(uniFrames) && $stable(mcFrames) && $stable(uniBytes))
    else $error("filtered frame counted");

  bcastGate_a: assert property (@(posedge clock) disable iff (reset)
    !broadcastAccept |=> $stable(bcFrames) && $stable(bcBytes))
    else $error("broadcast counted while not accepted");

  pauseCount_a: assert property (@(posedge clock) disable iff (reset)
    (frameDone && !frameInfo.hasError && frameInfo.isPause)
    |=> pauseFrames == $past(pauseFrames) + 1'b1)
    else $error("pause frame not counted");

  byteStrip_a: assert property (@(posedge clock) disable iff (reset)
    (uniMcOk && frameInfo.isUnicast && control[rxs_pkg::CTL_FCS_STRIP]
     && !control[rxs_pkg::CTL_VLAN_STRIP] && frameInfo.length > 16'h0004)
    |=> uniBytes == $past(uniBytes) + BYTE_WIDTH'($past(frameInfo.length) - 16'h0004))
    else $error("fcs bytes not stripped");

  oversize_a: assert property (@(posedge clock) disable iff (reset)
    (binOk && frameInfo.length == 16'h05ef) |=> binCount[6] == $past(binCount[6]) + 1'b1)
    else $error("oversize frame not counted");

  lpiClear_a: assert property (@(posedge clock) disable iff (reset)
    !lpiFeatureEnable |=> lpiTransitions == '0 && lpiTime == '0)
    else $error("idle counters not cleared");

  sequence lpiRise_s;
    !lpiIndication ##1 lpiIndication;
  endsequence

  lpiEdge_a: assert property (@(posedge clock) disable iff (reset)
    lpiRise_s ##0 lpiFeatureEnable
    |=> lpiTransitions == $past(lpiTransitions) + 1'b1)
    else $error("idle edge not counted");

  lpiTime_a: assert property (@(posedge clock) disable iff (reset)
    (lpiFeatureEnable && lpiIndication)[*8] ##1 (lpiFeatureEnable && lpiIndication)[*8]
    ##1 (lpiFeatureEnable && lpiIndication)[*8] |-> lpiTime != $past(lpiTime, 23))
    else $error("idle time not advancing");

  // Error-free report that survived the receive buffer
  sequence keptFrame_s;
    frameDone && !frameInfo.hasError && !frameInfo.overflow;
  endsequence

  bcFrameCount_a: assert property (@(posedge clock) disable iff (reset)
    keptFrame_s ##0 (frameInfo.isBroadcast && broadcastAccept)
    |=> bcFrames == $past(bcFrames) + 1'b1)
    else $error("broadcast frame not counted");

  mcFrameCount_a: assert property (@(posedge clock) disable iff (reset)
    keptFrame_s ##0 (frameInfo.isMulticast && !frameInfo.filterFail && !pauseDropped)
    |=> mcFrames == $past(mcFrames) + 1'b1)
    else $error("multicast frame not counted");

  // Pause exclusion applies to the shortest bin only; filter exclusion applies to every bin
  shortBin_a: assert property (@(posedge clock) disable iff (reset)
    keptFrame_s ##0 (frameInfo.length == rxs_pkg::LEN_64 && !frameInfo.filterFail
                     && !pauseDropped)
    |=> binCount[0] == $past(binCount[0]) + 1'b1)
    else $error("64-byte frame not counted");

  txFcsCount_a: assert property (@(posedge clock) disable iff (reset)
    txBadFcsFrame |=> txFcsErrors == $past(txFcsErrors) + 1'b1)
    else $error("bad checksum frame not counted");

endmodule

// >>> rxs_far_model.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Receive path and filter engine: one end-of-frame report per cycle from a queue
module rxs_far_model (
  input wire logic clock,
  output logic frameDone,
  output rxs_pkg::rxs_frame_type frameInfo
);
  rxs_pkg::rxs_frame_type pending[$];

  initial begin
    frameDone = 1'b0;
    frameInfo = '0;
  end

  // Queue lets reports go out back to back
  task automatic push(input rxs_pkg::rxs_frame_type f);
    pending.push_back(f);
  endtask

  function automatic int depth();
    return pending.size();
  endfunction

  // Info inverted between reports, so stale status can never pass for valid
  always @(posedge clock) begin
    if (pending.size() > 0) begin
      frameDone <= 1'b1;
      frameInfo <= pending.pop_front();
    end else begin
      frameDone <= 1'b0;
      frameInfo <= ~frameInfo;
    end
  end
endmodule

// >>> rx_ethernet_statistics_counters_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin samplesChecked++; if ((s) !== (e)) begin errTotal++; \
  $display("[FAIL] %s expected %h seen %h", n, e, s); end end

module rx_ethernet_statistics_counters_tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic lpiIndication = 1'b0;
  logic suspendStateZero = 1'b0;
  logic suspendStateThree = 1'b0;
  logic txBadFcsFrame = 1'b0;
  logic frameDone;
  rxs_pkg::rxs_frame_type frameInfo;
  rxs_pkg::rxs_frame_type f;
  rxs_pkg::rxs_bus_type bus = '0;
  logic [31:0] readData;
  logic [31:0] rd;
  logic [31:0] expVal [0:16];
  logic [4:0] ctl;
  int kind;
  int errTotal = 0;
  int samplesChecked = 0;
  int cycles = 0;
  // Whole run needs about a thousand cycles; ceiling leaves wide margin
  localparam int CAP = 40000;
  localparam logic [15:0] LENS [0:13] = '{16'h0040, 16'h003f, 16'h0041, 16'h007f,
    16'h0080, 16'h00ff, 16'h0100, 16'h01ff, 16'h0200, 16'h03ff, 16'h0400, 16'h05ee,
    16'h05ef, 16'h0003};
  localparam logic [4:0] CTLS [0:3] = '{5'h02, 5'h18, 5'h1b, 5'h15};

  always #25 clock = ~clock;

  rxs_counters dut (
    .clock(clock),
    .reset(reset),
    .frameDone(frameDone),
    .frameInfo(frameInfo),
    .lpiIndication(lpiIndication),
    .suspendStateZero(suspendStateZero),
    .suspendStateThree(suspendStateThree),
    .txBadFcsFrame(txBadFcsFrame),
    .bus(bus),
    .readData(readData)
  );

  rxs_far_model mdl (
    .clock(clock),
    .frameDone(frameDone),
    .frameInfo(frameInfo)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic closeOut();
    $display("checked %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == CAP) begin
      errTotal++;
      closeOut();
    end
  end

  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus.addr <= a;
    bus.writeData <= d;
    bus.writeStrobe <= 1'b1;
    @(posedge clock);
    bus.writeStrobe <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe edge
  task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    bus.addr <= a;
    bus.readStrobe <= 1'b1;
    @(posedge clock);
    bus.readStrobe <= 1'b0;
    #1 d = readData;
  endtask

  task automatic checkAll();
    for (int i = 0; i < 17; i++) begin
      rdReg(8'(rxs_pkg::OFF_UNI_BYTES + 4 * i), rd);
      `CHK($sformatf("offset %h", 8'(28 + 4 * i)), expVal[i], rd)
    end
  endtask

  // Length bin: 0 for 64 bytes, 1..6 upward, 7 for runts
  function automatic int binOf(input logic [15:0] n);
    if (n < rxs_pkg::LEN_64) return 7;
    if (n == rxs_pkg::LEN_64) return 0;
    if (n <= rxs_pkg::LEN_127) return 1;
    if (n <= rxs_pkg::LEN_255) return 2;
    if (n <= rxs_pkg::LEN_511) return 3;
    if (n <= rxs_pkg::LEN_1023) return 4;
    if (n <= rxs_pkg::LEN_1518) return 5;
    return 6;
  endfunction

  // Frame counters are 20 bits wide and wrap
  task automatic inc(input int i);
    expVal[i] = (expVal[i] + 1) & 32'h000fffff;
  endtask

  task automatic addFrame(input rxs_pkg::rxs_frame_type g);
    logic keep;
    logic [15:0] n;
    int b;
    if (!g.hasError) begin
      keep = !g.filterFail && !g.overflow && !(g.isPause && !ctl[rxs_pkg::CTL_PAUSE_FWD]);
      n = g.length;
      if (ctl[rxs_pkg::CTL_VLAN_STRIP] && g.hasVlan) n = (n > 4) ? n - 16'h0004 : '0;
      if (ctl[rxs_pkg::CTL_FCS_STRIP]) n = (n > 4) ? n - 16'h0004 : '0;
      if (keep && g.isUnicast) begin
        inc(3);
        expVal[0] += n;
      end
      if (keep && g.isMulticast) begin
        inc(5);
        expVal[2] += n;
      end
      if (ctl[rxs_pkg::CTL_BCAST] && !g.overflow && g.isBroadcast) begin
        inc(4);
        expVal[1] += n;
      end
      if (g.isPause) inc(6);
      b = binOf(g.length);
      if (b == 0 && keep) inc(7);
      if (b > 0 && b < 7 && !g.filterFail && !g.overflow) inc(7 + b);
    end
    mdl.push(g);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hf612));
    ctl = rxs_pkg::CTL_RESET;
    foreach (expVal[i]) expVal[i] = '0;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    // Reset values, control default, unmapped read, one-cycle read data
    checkAll();
    rdReg(8'h60, rd);
    `CHK("unmapped", 32'h0, rd)
    rdReg(rxs_pkg::OFF_CONTROL, rd);
    `CHK("control", {27'h0, rxs_pkg::CTL_RESET}, rd)
    @(posedge clock);
    #1 `CHK("read idle", 32'h0, readData)
    $display("test reset done");
    // Corner lengths first in each batch, then random reports back to back
    for (int t = 0; t < 4; t++) begin
      ctl = CTLS[t];
      wrReg(rxs_pkg::OFF_CONTROL, {27'h0, ctl});
      for (int k = 0; k < 90; k++) begin
        f = '0;
        f.length = (k < 14) ? LENS[k] : 16'($urandom_range(1, 1600));
        kind = $urandom_range(0, 2);
        f.isUnicast = (kind == 0);
        f.isBroadcast = (kind == 1);
        f.isMulticast = (kind == 2);
        f.hasVlan = 1'($urandom());
        f.isPause = ($urandom_range(0, 3) == 0);
        f.hasError = ($urandom_range(0, 7) == 0);
        f.filterFail = ($urandom_range(0, 5) == 0);
        f.overflow = ($urandom_range(0, 7) == 0);
        addFrame(f);
      end
      for (int w = 0; w < 200 && mdl.depth() > 0; w++) @(posedge clock);
      repeat (2) @(posedge clock);
      if (t == 3) wrReg(rxs_pkg::OFF_UNI_FRAMES, 32'hffffffff);
      checkAll();
      $display("test frames %0d done", t);
    end
    // Idle periods across both suspend states and normal power
    for (int p = 0; p < 3; p++) begin
      @(posedge clock);
      suspendStateZero <= (p == 1);
      suspendStateThree <= (p == 2);
      lpiIndication <= 1'b1;
      // Status read inside the idle period keeps it 100 cycles long
      repeat (97) @(posedge clock);
      rdReg(rxs_pkg::OFF_STATUS, rd);
      `CHK("status", {30'h0, p != 0, 1'b1}, rd)
      @(posedge clock);
      lpiIndication <= 1'b0;
      repeat (5) @(posedge clock);
    end
    rdReg(rxs_pkg::OFF_LPI_TRANS, rd);
    `CHK("lpi edges", 32'h3, rd)
    rdReg(rxs_pkg::OFF_LPI_TIME, rd);
    `CHK("lpi time", 32'h0000000f, rd)
    // Clearing by feature disable, and no counting meanwhile
    ctl = ctl & 5'h1b;
    wrReg(rxs_pkg::OFF_CONTROL, {27'h0, ctl});
    @(posedge clock);
    lpiIndication <= 1'b1;
    repeat (30) @(posedge clock);
    lpiIndication <= 1'b0;
    $display("test idle done");
    // Bad checksum pulses, several back to back
    for (int p = 0; p < 6; p++) begin
      @(posedge clock);
      txBadFcsFrame <= (p != 3);
    end
    @(posedge clock);
    txBadFcsFrame <= 1'b0;
    expVal[16] = 32'h5;
    checkAll();
    $display("test transmit done");
    closeOut();
  end
endmodule
